// file: design/dph_top.sv
// DMA port handshake and configuration block with register port and transfer FIFO
`timescale 1ns/1ps
module dph_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire dph_pkg::dph_bus_req_t bus_in,
  output logic [15:0] rdata_out,
  input wire dph_pkg::dph_pins_in_t pins_in,
  output dph_pkg::dph_pins_out_t pins_out,
  input wire logic [15:0] fill_data_in,
  input wire logic fill_valid_in,
  output logic fill_ready_out,
  output logic [15:0] drain_data_out,
  output logic drain_valid_out,
  input wire logic drain_ready_in,
  input wire logic pio_start_in,
  output logic pio_wide_out,
  output dph_pkg::dph_cfg_t cfg_out,
  output logic [2:0] pio_timing_out
);
  import dph_pkg::*;

  // ========================================================================
  // State
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_GAP} dph_req_t;
  typedef struct packed {
    logic [15:0] config_reg;
    logic [1:0] control;
    logic configured;
    logic [DPH_CNT_W-1:0] count;
    logic [4:0] burst_left;
    dph_req_t req_state;
    logic [15:0] rdata;
    logic [15:0] out_data;
    logic out_oe;
    logic [15:0] cap_data;
    logic cap_valid;
    logic strobe_q;
    logic pio_wide;
  } dph_st_t;

  dph_st_t st;
  dph_st_t next_st;
  dph_cfg_t cfg;
  logic inbound;
  logic master;
  logic cap_strobe;
  logic drv_strobe;
  logic strobe_now;
  logic unit_done;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic room_ok;
  logic [4:0] units;

  // ========================================================================
  // Configuration decode
  always_comb begin
    cfg.pio = st.config_reg[DPH_CFG_PIO_LO +: 3];
    cfg.pio_rsvd = (cfg.pio > DPH_PIO_MAX);
    cfg.master = st.control[DPH_CTL_MASTER_BIT];
    cfg.counter_used = cfg.master || !st.config_reg[DPH_CFG_DISCNT_BIT];
    cfg.burst = st.config_reg[DPH_CFG_BURST_LO +: 3];
    cfg.strobe_mode = st.config_reg[DPH_CFG_MODE_LO +: 2];
    cfg.wide = st.config_reg[DPH_CFG_WIDTH_BIT];
    cfg.strobe_bad = (cfg.strobe_mode == 2'h3) ||
                     (cfg.strobe_mode == DPH_STB_ACK2 && !cfg.wide);
  end
  assign cfg_out = cfg;
  assign pio_timing_out = cfg.pio_rsvd ? 3'h0 : cfg.pio;
  assign inbound = st.control[DPH_CTL_DIR_BIT];
  assign master = cfg.master;

  // Strobe selection per mode, role and direction; ultra signalling untouched
  always_comb begin
    case (cfg.strobe_mode)
      DPH_STB_RW: begin
        cap_strobe = master ? pins_in.rd_strobe_in : pins_in.wr_strobe_in;
        drv_strobe = master ? pins_in.wr_strobe_in : pins_in.rd_strobe_in;
      end
      DPH_STB_ACK1: begin
        cap_strobe = master ? pins_in.rd_strobe_in : pins_in.ack_in;
        drv_strobe = master ? pins_in.ack_in : pins_in.rd_strobe_in;
      end
      DPH_STB_ACK2: begin
        cap_strobe = pins_in.ack_in && cfg.wide;
        drv_strobe = pins_in.ack_in && cfg.wide;
      end
      default: begin
        cap_strobe = 1'b0;
        drv_strobe = 1'b0;
      end
    endcase
  end
  assign strobe_now = inbound ? cap_strobe : drv_strobe;
  assign unit_done = strobe_now && !st.strobe_q; // Rising edge ends one unit

  // ========================================================================
  // FIFO in the data path
  assign fifo_in_valid = inbound ? st.cap_valid : fill_valid_in;
  assign fifo_in_data = inbound ? st.cap_data : fill_data_in;
  assign fill_ready_out = !inbound && fifo_in_ready;
  assign fifo_out_ready = inbound ? drain_ready_in : (unit_done && !st.out_oe);
  assign drain_valid_out = inbound && fifo_out_valid;
  assign drain_data_out = fifo_out_data;
  assign room_ok = inbound ? !fifo_full : !fifo_empty;

  dph_fifo #(.WIDTH(DPH_DATA_W), .DEPTH(DPH_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .flush_in(1'b0),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  assign units = dph_burst_units(cfg.burst);

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.strobe_q = strobe_now;
    next_st.rdata = 16'h0000;
    next_st.pio_wide = 1'b0;
    // Register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        DPH_ADDR_CONFIG: begin
          next_st.config_reg = bus_in.wdata & DPH_CFG_WMASK;
          next_st.configured = 1'b1;
        end
        DPH_ADDR_CONTROL: next_st.control = bus_in.wdata[1:0];
        DPH_ADDR_COUNT: next_st.count = bus_in.wdata;
        default: next_st.control = st.control;
      endcase
    end
    // Register reads, data one cycle later
    if (bus_in.rd) begin
      case (bus_in.addr)
        DPH_ADDR_CONFIG: next_st.rdata = st.config_reg;
        DPH_ADDR_CONTROL: next_st.rdata = {14'h0000, st.control};
        DPH_ADDR_STATUS: next_st.rdata = {8'h00, fifo_full, fifo_empty,
                                          cfg.strobe_bad, cfg.pio_rsvd,
                                          1'b0, st.req_state == ST_REQ,
                                          st.configured, cfg.counter_used};
        DPH_ADDR_COUNT: next_st.rdata = st.count;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Programmed-I/O command is always a 16-bit transfer
    if (pio_start_in) begin
      next_st.pio_wide = 1'b1;
    end
    // Inbound capture into FIFO
    if (st.cap_valid && fifo_in_ready) begin
      next_st.cap_valid = 1'b0;
    end
    if (inbound && unit_done) begin
      next_st.cap_data = cfg.wide ? pins_in.data_in : {8'h00, pins_in.data_in[7:0]};
      next_st.cap_valid = 1'b1;
    end
    // Outbound drive from FIFO
    if (!inbound && unit_done && fifo_out_valid) begin
      next_st.out_data = cfg.wide ? fifo_out_data : {8'h00, fifo_out_data[7:0]};
      next_st.out_oe = 1'b1;
    end else if (!strobe_now) begin
      next_st.out_oe = 1'b0;
    end
    // Transfer counter
    if (unit_done && cfg.counter_used && st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
    // Request pacing state machine
    case (st.req_state)
      ST_IDLE: begin
        if (!master && st.configured && cfg.burst != DPH_BURST_RSVD && room_ok &&
            (!cfg.counter_used || st.count != '0)) begin
          next_st.req_state = ST_REQ;
          next_st.burst_left = units;
        end
      end
      ST_REQ: begin
        if (cfg.burst == DPH_BURST_HOLD) begin
          if (!room_ok || (cfg.counter_used && st.count == '0)) begin
            next_st.req_state = ST_IDLE;
          end
        end else if (!room_ok) begin
          next_st.req_state = ST_IDLE;
        end else if (unit_done) begin
          next_st.burst_left = st.burst_left - 1'b1;
          if (st.burst_left == 5'h01) begin
            next_st.req_state = ST_GAP;
          end
        end
      end
      ST_GAP: next_st.req_state = ST_IDLE; // One gap cycle, then idle: request negated at least two cycles between bursts
      default: next_st.req_state = ST_IDLE;
    endcase
    if (master || cfg.burst == DPH_BURST_RSVD) begin
      next_st.req_state = ST_IDLE;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '0;
      st.config_reg <= DPH_CFG_RESET;
      st.req_state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  assign rdata_out = st.rdata;
  assign pio_wide_out = st.pio_wide;
  assign pins_out.dma_request = (st.req_state == ST_REQ);
  assign pins_out.dma_request_oe = st.configured;
  assign pins_out.data = st.out_data;
  assign pins_out.data_oe = st.out_oe;
endmodule : dph_top

// file: common/dph_pkg.sv
// Package with register map, field layout and types for the DMA port handshake block
// ==========================================================================
// Operation
// - Timing field codes 0 to 4 pick programmed-I/O timing modes 0 to 4; codes 5 to 7 are reserved.
// - In slave role a set counter-disable bit makes the port ignore the transfer counter; master role always counts.
// - The burst field sets burst length and request pacing and acts only in the generic slave role.
// - Burst code 0 holds the request until the last unit moves or the FIFO is full (writes) or empty (reads).
// - Burst codes 1 to 6 assert then negate the request once per 1, 2, 4, 8, 12 or 16 units.
// - The strobe-mode field changes only slave and multiword master handshakes, never ultra signalling.
// - Strobe mode 0 captures on read strobe (master) or write strobe (slave), drives on write (master) or read (slave).
// - Strobe mode 1 captures on read strobe (master) or acknowledge (slave), drives on acknowledge (master) or read (slave).
// - Strobe mode 2 uses the acknowledge for both directions in both roles, only on a 16-bit bus; mode 3 is reserved.
// - The width bit selects an 8-bit bus when 0 and a 16-bit bus when 1.
// - The request output stays undriven until software has written the configuration register once.
// - In paced burst codes the request asserts only with FIFO space (write) or FIFO data (read).
// - In paced burst codes the pacing stops as soon as the transfer FIFO becomes full (writes) or empty (reads).
// - A programmed-I/O transfer started by command is always 16 bits wide.
// - The master-select bit picks generic slave role when 0 and multiword master role when 1.
package dph_pkg;

  // ========================================================================
  // Register map
  localparam logic [7:0] DPH_ADDR_CONFIG = 8'h38;
  localparam logic [7:0] DPH_ADDR_CONTROL = 8'h3C;
  localparam logic [7:0] DPH_ADDR_STATUS = 8'h40;
  localparam logic [7:0] DPH_ADDR_COUNT = 8'h44;

  // ========================================================================
  // Configuration fields and reset values
  localparam int DPH_CFG_WIDTH_BIT = 0;
  localparam int DPH_CFG_MODE_LO = 2;
  localparam int DPH_CFG_BURST_LO = 4;
  localparam int DPH_CFG_DISCNT_BIT = 7;
  localparam int DPH_CFG_PIO_LO = 8;
  localparam int DPH_CTL_MASTER_BIT = 0;
  localparam int DPH_CTL_DIR_BIT = 1;
  localparam logic [15:0] DPH_CFG_RESET = 16'h0001;
  localparam logic [15:0] DPH_CFG_WMASK = 16'h7FFD;
  localparam logic [2:0] DPH_PIO_MAX = 3'h4;
  localparam logic [2:0] DPH_BURST_HOLD = 3'h0;
  localparam logic [2:0] DPH_BURST_RSVD = 3'h7;
  localparam logic [1:0] DPH_STB_RW = 2'h0;
  localparam logic [1:0] DPH_STB_ACK1 = 2'h1;
  localparam logic [1:0] DPH_STB_ACK2 = 2'h2;

  // ========================================================================
  // Buffer and counting sizes
  localparam int DPH_DATA_W = 16;
  localparam int DPH_FIFO_DEPTH = 4;
  localparam int DPH_CNT_W = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dph_bus_req_t;

  typedef struct packed {
    logic ack_in;
    logic rd_strobe_in;
    logic wr_strobe_in;
    logic [15:0] data_in;
  } dph_pins_in_t;

  typedef struct packed {
    logic dma_request;
    logic dma_request_oe;
    logic [15:0] data;
    logic data_oe;
  } dph_pins_out_t;

  // Decoded configuration
  typedef struct packed {
    logic [2:0] pio;
    logic pio_rsvd;
    logic counter_used;
    logic [2:0] burst;
    logic [1:0] strobe_mode;
    logic strobe_bad;
    logic wide;
    logic master;
  } dph_cfg_t;

  // Burst code to units per request, 0 for hold and reserved
  function automatic logic [4:0] dph_burst_units(input logic [2:0] code);
    case (code)
      3'h1: dph_burst_units = 5'h01;
      3'h2: dph_burst_units = 5'h02;
      3'h3: dph_burst_units = 5'h04;
      3'h4: dph_burst_units = 5'h08;
      3'h5: dph_burst_units = 5'h0C;
      3'h6: dph_burst_units = 5'h10;
      default: dph_burst_units = 5'h00;
    endcase
  endfunction : dph_burst_units

endpackage : dph_pkg

// file: design/dph_mem.sv
// Small register-file memory with registered read data
`timescale 1ns/1ps
module dph_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port and registered read port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule : dph_mem

// file: design/dph_fifo.sv
// Transfer FIFO with valid and ready on both sides, show-ahead output register
`timescale 1ns/1ps
module dph_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic full_out,
  output logic empty_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [WIDTH-1:0] head;
    logic head_valid;
    logic q_stale;
  } dph_fifo_st_t;

  dph_fifo_st_t st;
  dph_fifo_st_t next_st;
  logic [AW:0] used;
  logic push;
  logic pop;
  logic [WIDTH-1:0] mem_q;
  logic mem_ok;

  assign used = st.wptr - st.rptr;
  // Head register counts toward the depth, so the FIFO never holds more than DEPTH words
  assign full_out = ((used + (AW+1)'(st.head_valid)) == (AW+1)'(DEPTH));
  assign empty_out = !st.head_valid;
  assign in_ready_out = !full_out;
  assign push = in_valid_in && !full_out;
  assign out_valid_out = st.head_valid;
  assign out_data_out = st.head;

  dph_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_in(clk_in),
    .we_in(push),
    .waddr_in(st.wptr[AW-1:0]),
    .wdata_in(in_data_in),
    .raddr_in(next_st.rptr[AW-1:0]), // Look ahead so read data match the next pointer
    .rdata_out(mem_q)
  );

  // Pop from storage into the head register
  always_comb begin
    next_st = st;
    pop = 1'b0;
    mem_ok = (used != '0) && !st.q_stale;
    if (push) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (st.head_valid && out_ready_in) begin
      next_st.head_valid = 1'b0;
    end
    if (!next_st.head_valid && mem_ok) begin
      pop = 1'b1;
    end
    if (pop) begin
      next_st.head = mem_q;
      next_st.head_valid = 1'b1;
      next_st.rptr = st.rptr + 1'b1;
    end
    // Slot written at the same edge it is read comes out old for one cycle
    next_st.q_stale = push && (st.wptr[AW-1:0] == next_st.rptr[AW-1:0]);
    if (flush_in) begin
      next_st = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : dph_fifo

// file: dv/dph_chk_sva.sv
// Checker of the DMA port handshake block, bound to its top module
`timescale 1ns/1ps
module dph_chk_sva
  import dph_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire dph_pkg::dph_bus_req_t bus_in,
  input wire dph_pkg::dph_pins_out_t pins_out,
  input wire logic pio_start_in,
  input wire logic pio_wide_out,
  input wire dph_pkg::dph_cfg_t cfg_out,
  input wire logic [2:0] pio_timing_out
);
  logic seen;
  logic cfg_wr;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Configuration register write
  assign cfg_wr = bus_in.wr && (bus_in.addr == DPH_ADDR_CONFIG);
  // Remembers the first configuration write since reset
  always_ff @(posedge clk_in) begin
    if (reset_in) seen <= 1'b0;
    else if (cfg_wr) seen <= 1'b1;
  end
  // ==========
  // Properties
  pio_map_a: assert property (
    pio_timing_out == ((cfg_out.pio > DPH_PIO_MAX) ? 3'h0 : cfg_out.pio))
    else $error("pio timing code wrong");
  counter_use_a: assert property (
    cfg_out.master |-> cfg_out.counter_used)
    else $error("master role ignores counter");
  burst_load_a: assert property (
    cfg_wr |=> cfg_out.burst == $past(bus_in.wdata[6:4]))
    else $error("burst field not taken");
  width_load_a: assert property (
    cfg_wr |=> cfg_out.wide == $past(bus_in.wdata[0]))
    else $error("width bit not taken");
  master_quiet_a: assert property (
    cfg_out.master [*3] |-> !pins_out.dma_request)
    else $error("request raised in master role");
  rsvd_quiet_a: assert property (
    (cfg_out.burst == DPH_BURST_RSVD) [*3] |-> !pins_out.dma_request)
    else $error("request raised with reserved burst");
  strobe_bad_a: assert property (
    cfg_out.strobe_bad == ((cfg_out.strobe_mode == 2'h3) ||
      ((cfg_out.strobe_mode == DPH_STB_ACK2) && !cfg_out.wide)))
    else $error("strobe mode check wrong");
  req_undriven_a: assert property (
    !seen |-> !pins_out.dma_request_oe)
    else $error("request driven before configuration");
  pio_wide_a: assert property (
    pio_start_in |=> pio_wide_out)
    else $error("command transfer not 16 bit");
endmodule : dph_chk_sva

// file: dv/dph_far.sv
// Far-side DMA peer that answers requests with strobes
`timescale 1ns/1ps
module dph_far
  import dph_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [1:0] sel_in,
  input wire dph_pkg::dph_pins_out_t dev_in,
  output dph_pkg::dph_pins_in_t pins_out,
  output logic [15:0] got_out,
  output logic [15:0] units_out
);
  // One unit per request: strobe held four cycles, then low for four before the next check
  initial begin
    pins_out = '0;
    got_out = '0;
    units_out = '0;
    forever begin
      @(posedge clk_in);
      if (go_in && dev_in.dma_request_oe && dev_in.dma_request) begin
        pins_out <= {sel_in == 2'h1, sel_in == 2'h2, sel_in == 2'h0,
          16'h1000 + units_out};
        units_out <= units_out + 16'h0001; // Counted as the strobe rises, like the device
        repeat (4) @(posedge clk_in);
        got_out <= dev_in.data;
        pins_out <= {3'b000, ~pins_out.data_in}; // Released bus shows inverse
        repeat (3) @(posedge clk_in);
      end
    end
  end
endmodule : dph_far

// file: dv/dph_top_bench.sv
// Self-checking bench of the DMA port handshake block
`timescale 1ns/1ps
module dph_top_bench;
  import dph_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  dph_bus_req_t bus = '0;
  dph_pins_in_t pins_in;
  dph_pins_out_t pins_out;
  dph_cfg_t cfg;
  logic [15:0] rdata, drain_data, got, units, fill_data = 16'h0000;
  logic fill_ready, drain_valid, pio_wide, fill_valid = 1'b0, go = 1'b0;
  logic drain_ready = 1'b1, pio_start = 1'b0, prev_req = 1'b0;
  logic [2:0] pio_t;
  logic [1:0] sel = 2'h0;
  int fails = 0;
  int comparisons = 0;
  int base = 0;
  int mark = 0;
  int runs[$];
  logic [15:0] words[$];
  // Clock of 20 ns
  always #10 clk_in = ~clk_in;
  dph_top u_dph_top (.clk_in(clk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(rdata),
    .pins_in(pins_in), .pins_out(pins_out), .fill_data_in(fill_data),
    .fill_valid_in(fill_valid), .fill_ready_out(fill_ready), .drain_data_out(drain_data),
    .drain_valid_out(drain_valid), .drain_ready_in(drain_ready), .pio_start_in(pio_start),
    .pio_wide_out(pio_wide), .cfg_out(cfg), .pio_timing_out(pio_t));
  dph_far u_dph_far (.clk_in(clk_in), .go_in(go), .sel_in(sel), .dev_in(pins_out),
    .pins_out(pins_in), .got_out(got), .units_out(units));
  // Units per request run and drained words
  always @(posedge clk_in) begin
    if (prev_req && !pins_out.dma_request) begin
      runs.push_back(int'(units) - mark);
      mark = units;
    end
    if (drain_valid && drain_ready) words.push_back(drain_data);
    prev_req <= pins_out.dma_request;
  end
  // ==========
  // Shared tasks
  function automatic int moved();
    return int'(units) - base;
  endfunction : moved
  function automatic logic [15:0] cw(input logic dc, input logic [2:0] b,
    input logic [1:0] m, input logic w);
    return {8'h00, dc, b, m, 1'b0, w};
  endfunction : cw
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    tick(1);
    bus.wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    tick(1);
    bus.rd <= 1'b0;
    tick(1);
    d = rdata;
  endtask : rd
  task automatic setup(input logic [1:0] ctl, input logic [15:0] c, input logic [15:0] n);
    // Reserved burst parks the request so the new code starts a fresh burst
    wr(DPH_ADDR_CONFIG, cw(1'b1, DPH_BURST_RSVD, DPH_STB_RW, 1'b1));
    wr(DPH_ADDR_CONTROL, {14'h0000, ctl});
    wr(DPH_ADDR_COUNT, n);
    wr(DPH_ADDR_CONFIG, c);
    tick(3);
    runs.delete();
    words.delete();
    base = units;
    mark = units;
  endtask : setup
  task automatic run(input int n);
    go <= 1'b1;
    for (int i = 0; i < 800 && moved() < n; i++) tick(1);
    go <= 1'b0;
    tick(30);
  endtask : run
  // ==========
  // Scenarios
  task automatic t_reset();
    logic [15:0] d;
    chk("req oe", 16'(pins_out.dma_request_oe), 16'h0000);
    rd(DPH_ADDR_CONFIG, d);
    chk("cfg reset", d, DPH_CFG_RESET);
    wr(DPH_ADDR_CONFIG, 16'hFFFF);
    chk("req oe on", 16'(pins_out.dma_request_oe), 16'h0001);
    rd(DPH_ADDR_CONFIG, d);
    chk("cfg mask", d, DPH_CFG_WMASK);
    rd(8'h10, d);
    chk("unmapped", d, 16'h0000);
  endtask : t_reset
  task automatic t_pio();
    logic [15:0] d;
    for (int c = 0; c < 8; c++) begin
      wr(DPH_ADDR_CONFIG, 16'(c) << DPH_CFG_PIO_LO);
      rd(DPH_ADDR_CONFIG, d);
      chk("pio back", d, 16'(c) << DPH_CFG_PIO_LO);
      chk("pio timing", 16'(pio_t), (c > 4) ? 16'h0000 : 16'(c));
      pio_start <= 1'b1;
      tick(1);
      pio_start <= 1'b0;
      tick(1);
      chk("pio wide", 16'(pio_wide), 16'h0001);
    end
  endtask : t_pio
  task automatic t_burst();
    int len[7] = '{0, 1, 2, 4, 8, 12, 16};
    for (int b = 1; b < 7; b++) begin
      setup(2'h2, cw(1'b1, 3'(b), DPH_STB_RW, 1'b1), 16'h0000);
      run(2 * len[b]);
      chk("paced run", 16'(runs[0]), 16'(len[b]));
    end
  endtask : t_burst
  task automatic t_hold();
    setup(2'h2, cw(1'b1, DPH_BURST_HOLD, DPH_STB_RW, 1'b1), 16'h0000);
    chk("cnt off", 16'(cfg.counter_used), 16'h0000);
    drain_ready <= 1'b0;
    run(DPH_FIFO_DEPTH + 1);
    chk("hold full", 16'(moved()), 16'(DPH_FIFO_DEPTH));
    drain_ready <= 1'b1;
    tick(10);
    chk("drained", 16'(words.size()), 16'(DPH_FIFO_DEPTH));
    foreach (words[k]) chk("drain word", words[k], 16'h1000 + 16'(base + k));
  endtask : t_hold
  task automatic t_count();
    logic [15:0] d;
    setup(2'h2, cw(1'b0, DPH_BURST_HOLD, DPH_STB_RW, 1'b1), 16'h0003);
    run(9);
    chk("counted", 16'(moved()), 16'h0003);
    rd(DPH_ADDR_COUNT, d);
    chk("count left", d, 16'h0000);
  endtask : t_count
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      sel <= (m == 0) ? 2'h0 : 2'h1;
      setup(2'h2, cw(1'b1, 3'h1, 2'(m), 1'b1), 16'h0000);
      run(1);
      chk("mode word", words[0], 16'h1000 + 16'(base));
    end
    setup(2'h2, cw(1'b1, 3'h1, DPH_STB_ACK2, 1'b0), 16'h0000);
    run(1);
    chk("narrow ack", 16'(words.size()), 16'h0000);
    chk("narrow flag", 16'(cfg.strobe_bad), 16'h0001);
    sel <= 2'h2;
  endtask : t_modes
  task automatic t_out();
    setup(2'h0, cw(1'b1, 3'h1, DPH_STB_RW, 1'b1), 16'h0000);
    fill_valid <= 1'b1;
    for (int k = 0; k < DPH_FIFO_DEPTH; k++) begin
      fill_data <= 16'hA500 + 16'(k);
      tick(1);
      for (int i = 0; i < 20 && fill_ready !== 1'b1; i++) tick(1);
    end
    fill_valid <= 1'b0;
    tick(2);
    chk("fifo full", 16'(fill_ready), 16'h0000);
    run(DPH_FIFO_DEPTH + 1);
    chk("sent", 16'(moved()), 16'(DPH_FIFO_DEPTH));
    chk("last word", got, 16'hA500 + 16'(DPH_FIFO_DEPTH - 1));
    chk("req idle", 16'(pins_out.dma_request), 16'h0000);
    chk("bus released", 16'(pins_out.data_oe), 16'h0000);
  endtask : t_out
  task automatic t_master();
    setup(2'h3, cw(1'b1, 3'h1, DPH_STB_RW, 1'b1), 16'h0005);
    chk("master cnt", 16'(cfg.counter_used), 16'h0001);
    chk("master", 16'(cfg.master), 16'h0001);
    run(1);
    chk("no request", 16'(moved()), 16'h0000);
  endtask : t_master
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    tick(10);
    reset_in <= 1'b0;
    tick(1);
    t_reset();
    t_pio();
    t_burst();
    t_hold();
    t_count();
    t_modes();
    t_out();
    t_master();
    wrap_up();
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule : dph_top_bench
bind dph_top dph_chk_sva u_dph_chk_sva (.clk_in(clk_in), .reset_in(reset_in),
  .bus_in(bus_in), .pins_out(pins_out), .pio_start_in(pio_start_in),
  .pio_wide_out(pio_wide_out), .cfg_out(cfg_out), .pio_timing_out(pio_timing_out));
